// >>> rtl/qdcc_top.sv
// Command and control logic of a quad 16-bit converter behind a serial link.
//
// Functional notes
// - 32-bit MSB-first frame, acts on edge 32
// - Command 1000 updates chain and reference
// - Setup bit 1 chain, bit 0 reference
// - Command 0100 applies power mode
// - Mode bits 9:8 select normal/1k/100k/tristate
// - Bits 3:0 select channels D to A
// - Clear pin acts on falling edge only
// - Clear loads input and output registers
// - Clear selection from frame bits 1:0
// - Selection maps 0000, 8000, ffff; 11 ignored
// - Clear selection resets to zero scale
// - Command 0101 writes clear selection
// - Clear mode ends at next frame end
// - Clear during a frame aborts it
// - Load pin low updates on edge 32
// - Load pin high holds; falling copies all
// - Command 0011 writes one, updates all
// - Command 0110 writes override mask bits 3:0
// - Override channels update immediately
// - Override mask resets to zero
`timescale 1ns/100ps
`default_nettype none
module qdcc_top
   import qdcc_pkg::*;
(
   input wire logic clk, // System clock, 50 MHz.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic frame_sel_n, // Frame select, active low.
   input wire logic shift_clk, // Serial shift clock from the host.
   input wire logic data_in, // Serial data, MSB first.
   input wire logic async_clear_n, // Clear pin, falling edge acts.
   input wire logic load_outputs_n, // Load pin, active low.
   output logic chain_mode_enable, // Daisy-chain mode enabled.
   output logic vref_enable, // On-chip reference turned on.
   output logic [1:0] clear_sel, // Stored clear code selection.
   output logic [3:0] load_override_mask, // Per-channel override.
   output logic clear_mode, // Outputs held at the clear code.
   output logic [7:0] pwr_mode, // Two mode bits per channel, A lowest.
   output logic [63:0] dac_code // Output register codes, A lowest.
);
   qdcc_pins_t pins;
   logic frameLevel;
   logic loadLevel;

   // Every pin crosses into the clk domain; shift clock edges are found here.
   // The link clock is only sampled, so each of its half periods must span
   // at least two clk cycles for an edge to be seen.
   qdcc_pin_sync uSclk (
      .clk(clk), .sys_rst(sys_rst), .pinIn(shift_clk),
      .level(), .fell(pins.sclkFall)
   );
   qdcc_pin_sync uFrame (
      .clk(clk), .sys_rst(sys_rst), .pinIn(frame_sel_n),
      .level(frameLevel), .fell()
   );
   qdcc_pin_sync uClr (
      .clk(clk), .sys_rst(sys_rst), .pinIn(async_clear_n),
      .level(), .fell(pins.clrFall)
   );
   qdcc_pin_sync uLoad (
      .clk(clk), .sys_rst(sys_rst), .pinIn(load_outputs_n),
      .level(loadLevel), .fell()
   );

   // Both pins are active low, so the struct carries the asserted sense.
   assign pins.frameLow = ~frameLevel;
   assign pins.loadLow = ~loadLevel;

   // Frame capture state.
   qdcc_state_t state_ff, nxt_state;
   logic [31:0] shift_ff, nxt_shift;
   logic [5:0] count_ff, nxt_count;
   logic frameDone;
   qdcc_frame_t frm;
   logic frameActive;
   logic [2:0] sd_ff, nxt_sd;
   logic sdSample_ff, nxt_sdSample;

   // A frame is open while the synchronised select is low; a bounce on the
   // select line only counts once the sync stages agree.
   assign frameActive = pins.frameLow;

   // Shift on each falling edge; the 32nd completes the frame.
   always_comb begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_count = count_ff;
      frameDone = 1'b0;
      case (state_ff)
         QDCC_IDLE: begin
            // The count restarts so no bit of an earlier frame is reused.
            nxt_count = 6'h00;
            if (frameActive) begin
               nxt_state = QDCC_SHIFT;
            end
         end
         QDCC_SHIFT: begin
            if (!frameActive) begin
               nxt_state = QDCC_IDLE;
            end else if (pins.clrFall) begin
               // The rest of an aborted frame is ignored until select rises.
               nxt_state = QDCC_DONE;
            end else if (pins.sclkFall) begin
               nxt_shift = {shift_ff[30:0], sdSample_ff};
               nxt_count = count_ff + 6'h01;
               if (count_ff == FRAME_LAST) begin
                  frameDone = 1'b1;
                  nxt_state = QDCC_DONE;
               end
            end
         end
         QDCC_DONE: begin
            // Bits beyond the 32nd are ignored until select rises.
            if (!frameActive) begin
               nxt_state = QDCC_IDLE;
            end
         end
         default: nxt_state = QDCC_IDLE;
      endcase
   end

   // Frame capture flops.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= QDCC_IDLE;
         shift_ff <= 32'h0000_0000;
         count_ff <= 6'h00;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
      end
   end

   // Data runs one stage behind the clock's edge detector, so the bit taken
   // on a falling edge is the one that stood before that edge.
   always_comb begin
      nxt_sd = {sd_ff[1:0], data_in};
      nxt_sdSample = sd_ff[2];
   end

   // Data sampling flops.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sd_ff <= 3'h0;
         sdSample_ff <= 1'b0;
      end else begin
         sd_ff <= nxt_sd;
         sdSample_ff <= nxt_sdSample;
      end
   end

   // Field split of the completed word, MSB first.
   logic [31:0] fullWord;
   assign fullWord = {shift_ff[30:0], sdSample_ff};
   assign frm.cmd = fullWord[CMD_MSB:CMD_LSB];
   assign frm.addr = fullWord[ADDR_MSB:ADDR_LSB];
   assign frm.code = fullWord[CODE_MSB:CODE_LSB];
   assign frm.low = fullWord[3:0];
   assign frm.pd = fullWord[PD_MSB:PD_LSB];

   // Control registers and channel registers.
   logic [1:0] setup_ff, nxt_setup;
   logic [1:0] clrsel_ff, nxt_clrsel;
   logic [3:0] mask_ff, nxt_mask;
   logic clrMode_ff, nxt_clrMode;
   logic [7:0] pwr_ff, nxt_pwr;
   logic [15:0] inReg_ff [4];
   logic [15:0] dacReg_ff [4];
   logic [15:0] nxtIn [4];
   logic [15:0] nxtDac [4];
   logic [15:0] clrCode;
   logic [63:0] dacOut;

   // Clear code lookup from the stored selection.
   // Selection 11 is never stored, so the default branch means zero.
   always_comb begin
      case (clrsel_ff)
         2'h1: clrCode = CLR_MID;
         2'h2: clrCode = CLR_FULL;
         default: clrCode = CLR_ZERO;
      endcase
   end

   // Control registers change only on a completed, unaborted frame; clear mode is also set by a clear edge.
   always_comb begin
      nxt_setup = setup_ff;
      nxt_clrsel = clrsel_ff;
      nxt_mask = mask_ff;
      nxt_clrMode = clrMode_ff;
      nxt_pwr = pwr_ff;
      // A clear edge wins over a frame ending in the same cycle.
      if (pins.clrFall) begin
         nxt_clrMode = 1'b1;
      end else if (frameDone) begin
         nxt_clrMode = 1'b0;
         case (frm.cmd)
            CMD_SETUP: nxt_setup = frm.low[1:0];
            CMD_CLRSEL: begin
               if (frm.low[1:0] != CLRSEL_NOP) begin
                  nxt_clrsel = frm.low[1:0];
               end
            end
            CMD_LDMASK: nxt_mask = frm.low;
            CMD_PWR: begin
               for (int c = 0; c < 4; c++) begin
                  if (frm.low[c]) begin
                     nxt_pwr[2*c +: 2] = frm.pd;
                  end
               end
            end
            default: nxt_setup = setup_ff;
         endcase
      end
   end

   // Channel registers, one slice per channel.
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : gChan
         logic hit;
         logic isWrite;
         logic takeNow;
         logic copyIn;
         // A frame addresses this channel by number or by broadcast.
         assign hit = (frm.addr == 4'(ch)) || (frm.addr == ADDR_ALL);
         // Only the write commands touch the input register.
         assign isWrite = frameDone && hit &&
            (frm.cmd == CMD_WR_INPUT || frm.cmd == CMD_WR_UPD_ALL ||
             frm.cmd == CMD_WR_UPD_ONE);
         // Pin low, override set or a write-and-update command puts the new
         // code straight into the output register.
         assign takeNow = pins.loadLow || mask_ff[ch] ||
            frm.cmd == CMD_WR_UPD_ALL || frm.cmd == CMD_WR_UPD_ONE;
         // Software load copies every input register; the update command
         // copies only the channels selected by the low bits.
         assign copyIn = frameDone && (frm.cmd == CMD_WR_UPD_ALL ||
            frm.cmd == CMD_WR_UPD_ONE ||
            (frm.cmd == CMD_UPD_DAC && frm.low[ch]));
         // The clear edge has priority, since a frame ending in the same
         // cycle is abandoned then.
         always_comb begin
            nxtIn[ch] = inReg_ff[ch];
            nxtDac[ch] = dacReg_ff[ch];
            if (pins.clrFall) begin
               nxtIn[ch] = clrCode;
               nxtDac[ch] = clrCode;
            end else begin
               if (isWrite) begin
                  nxtIn[ch] = frm.code;
               end
               if (isWrite && takeNow) begin
                  nxtDac[ch] = frm.code;
               end else if (copyIn) begin
                  nxtDac[ch] = inReg_ff[ch];
               end else if (pins.loadLow) begin
                  nxtDac[ch] = inReg_ff[ch];
               end
            end
         end
         // Input and output registers of this channel.
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               inReg_ff[ch] <= CODE_RST;
               dacReg_ff[ch] <= CODE_RST;
            end else begin
               inReg_ff[ch] <= nxtIn[ch];
               dacReg_ff[ch] <= nxtDac[ch];
            end
         end
         assign dacOut[16*ch +: 16] = dacReg_ff[ch];
      end
   endgenerate

   // Control register flops; mask and selection reset to their defaults.
   // Power modes reset to normal operation on every channel.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         setup_ff <= SETUP_RST;
         clrsel_ff <= CLRSEL_RST;
         mask_ff <= LDMASK_RST;
         clrMode_ff <= 1'b0;
         pwr_ff <= {4{PWR_RST}};
      end else begin
         setup_ff <= nxt_setup;
         clrsel_ff <= nxt_clrsel;
         mask_ff <= nxt_mask;
         clrMode_ff <= nxt_clrMode;
         pwr_ff <= nxt_pwr;
      end
   end

   // Outputs are plain copies of flops, with no logic in between.
   assign chain_mode_enable = setup_ff[CHAIN_BIT];
   assign vref_enable = setup_ff[VREF_BIT];
   assign clear_sel = clrsel_ff;
   assign load_override_mask = mask_ff;
   assign clear_mode = clrMode_ff;
   assign pwr_mode = pwr_ff;
   assign dac_code = dacOut;
endmodule : qdcc_top
`default_nettype wire

// >>> rtl/qdcc_pkg.sv
// Package of constants and types for the quad converter command control.
package qdcc_pkg;
   localparam int FRAME_BITS = 32;
   localparam logic [5:0] FRAME_LAST = 6'h1f;
   // Field positions inside the 32-bit frame.
   localparam int CMD_MSB = 27;
   localparam int CMD_LSB = 24;
   localparam int ADDR_MSB = 23;
   localparam int ADDR_LSB = 20;
   localparam int CODE_MSB = 19;
   localparam int CODE_LSB = 4;
   localparam int PD_MSB = 9;
   localparam int PD_LSB = 8;
   localparam int CHAIN_BIT = 1;
   localparam int VREF_BIT = 0;
   // Command codes.
   localparam logic [3:0] CMD_WR_INPUT = 4'h0;
   localparam logic [3:0] CMD_UPD_DAC = 4'h1;
   localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WR_UPD_ONE = 4'h3;
   localparam logic [3:0] CMD_PWR = 4'h4;
   localparam logic [3:0] CMD_CLRSEL = 4'h5;
   localparam logic [3:0] CMD_LDMASK = 4'h6;
   localparam logic [3:0] CMD_SETUP = 4'h8;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   // Clear codes and reset values.
   localparam logic [15:0] CLR_ZERO = 16'h0000;
   localparam logic [15:0] CLR_MID = 16'h8000;
   localparam logic [15:0] CLR_FULL = 16'hffff;
   localparam logic [1:0] CLRSEL_NOP = 2'h3;
   localparam logic [1:0] CLRSEL_RST = 2'h0;
   localparam logic [3:0] LDMASK_RST = 4'h0;
   localparam logic [1:0] SETUP_RST = 2'h0;
   localparam logic [1:0] PWR_RST = 2'h0;
   localparam logic [15:0] CODE_RST = 16'h0000;

   typedef enum logic [1:0] {
      QDCC_PWR_NORMAL = 2'h0,
      QDCC_PWR_1K = 2'h1,
      QDCC_PWR_100K = 2'h2,
      QDCC_PWR_TRI = 2'h3
   } qdcc_pwr_t;

   // Frame state: idle, shifting, waiting for frame select to rise.
   typedef enum logic [1:0] {
      QDCC_IDLE = 2'b00,
      QDCC_SHIFT = 2'b01,
      QDCC_DONE = 2'b11
   } qdcc_state_t;

   // Decoded frame handed on the 32nd falling edge.
   typedef struct packed {
      logic [3:0] cmd;
      logic [3:0] addr;
      logic [15:0] code;
      logic [3:0] low;
      logic [1:0] pd;
   } qdcc_frame_t;

   // Synchronised pin levels and their edges.
   typedef struct packed {
      logic sclkFall;
      logic frameLow;
      logic clrFall;
      logic loadLow;
   } qdcc_pins_t;
endpackage : qdcc_pkg

// >>> rtl/qdcc_pin_sync.sv
// Three-stage synchroniser with edge detection for one outside pin.
`timescale 1ns/100ps
`default_nettype none
module qdcc_pin_sync (
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic pinIn, // Raw pin from outside the clock domain.
   output logic level, // Agreed level of the pin.
   output logic fell // One-cycle pulse on an agreed falling edge.
);
   logic [2:0] stage_ff;
   logic [2:0] nxt_stage;
   logic level_ff;
   logic nxt_level;

   // A change only counts once the second and third stages agree.
   always_comb begin
      nxt_stage = {stage_ff[1:0], pinIn};
      nxt_level = level_ff;
      if (stage_ff[1] == stage_ff[2]) begin
         nxt_level = stage_ff[2];
      end
   end

   // Every pin idles high, so the stages reset high and no false edge follows.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage_ff <= 3'h7;
         level_ff <= 1'b1;
      end else begin
         stage_ff <= nxt_stage;
         level_ff <= nxt_level;
      end
   end

   assign level = level_ff;
   assign fell = level_ff & ~nxt_level;
endmodule : qdcc_pin_sync
`default_nettype wire

// >>> verif/qdcc_top_chk.sv
// Concurrent checks on the command control ports, bound to the top.
`timescale 1ns/100ps
`default_nettype none
module qdcc_top_chk
   import qdcc_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Reset.
   input wire logic frame_sel_n, // Frame select.
   input wire logic shift_clk, // Shift clock.
   input wire logic data_in, // Serial data.
   input wire logic async_clear_n, // Clear pin.
   input wire logic load_outputs_n, // Load pin.
   input wire logic chain_mode_enable, // Chain mode.
   input wire logic vref_enable, // Reference on.
   input wire logic [1:0] clear_sel, // Clear selection.
   input wire logic [3:0] load_override_mask, // Override mask.
   input wire logic clear_mode, // Clear mode.
   input wire logic [7:0] pwr_mode, // Power modes.
   input wire logic [63:0] dac_code // Output codes.
);
   logic [15:0] clrCode;
   logic [15:0] cfg;
   // Code picked by the stored selection; the no-op value is never kept.
   assign clrCode = (clear_sel == 2'h1) ? CLR_MID :
      (clear_sel == 2'h2) ? CLR_FULL : CLR_ZERO;
   // Settings that only a finished frame may change.
   assign cfg = {chain_mode_enable, vref_enable, clear_sel,
      load_override_mask, pwr_mode};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_CLR_SET:
      assert property ($fell(async_clear_n) |-> ##[1:8] clear_mode)
      else $error("No clear mode after clear edge.");
   AST_CLR_EDGE:
      assert property ($rose(clear_mode) |-> $past(async_clear_n, 9))
      else $error("Clear mode without a clear edge.");
   AST_CLR_CODE:
      assert property ($rose(clear_mode) |-> ##[0:1] dac_code == {4{clrCode}})
      else $error("Outputs not at clear code.");
   AST_SEL_NOP:
      assert property (clear_sel != CLRSEL_NOP)
      else $error("No-op selection stored.");
   AST_CFG_FRAME:
      assert property ($changed(cfg) |-> !frame_sel_n)
      else $error("Setting changed outside a frame.");
   AST_CLR_EXIT:
      assert property ($fell(clear_mode) |-> !frame_sel_n)
      else $error("Clear mode left outside a frame.");
   AST_LOAD_HOLD:
      assert property ($changed(dac_code) && frame_sel_n &&
         $past(frame_sel_n, 8) |-> !load_outputs_n ||
         !$past(load_outputs_n, 6) || !async_clear_n)
      else $error("Outputs moved with load pin high.");
   AST_RST_VALUES:
      assert property (disable iff (1'b0) sys_rst && $past(sys_rst) |->
         clear_sel == CLRSEL_RST && load_override_mask == LDMASK_RST)
      else $error("Wrong values under reset.");
   COV_CLEAR: cover property ($rose(clear_mode));
   COV_EXIT: cover property ($fell(clear_mode));
   COV_MASK: cover property (load_override_mask != LDMASK_RST);
endmodule : qdcc_top_chk

bind qdcc_top qdcc_top_chk i_chk (
   .clk(clk), .sys_rst(sys_rst), .frame_sel_n(frame_sel_n),
   .shift_clk(shift_clk), .data_in(data_in), .async_clear_n(async_clear_n),
   .load_outputs_n(load_outputs_n), .chain_mode_enable(chain_mode_enable),
   .vref_enable(vref_enable), .clear_sel(clear_sel),
   .load_override_mask(load_override_mask), .clear_mode(clear_mode),
   .pwr_mode(pwr_mode), .dac_code(dac_code)
);
`default_nettype wire

// >>> verif/qdcc_host.sv
// Host model that sends framed words over the three-wire link.
`timescale 1ns/100ps
`default_nettype none
module qdcc_host (
   input wire logic clk, // System clock.
   output logic frameSelN, // Frame select, active low.
   output logic shiftClk, // Shift clock, idle high, still between frames.
   output logic dataIn // Serial data.
);
   // Idle levels before the first frame.
   initial begin
      frameSelN = 1'b1;
      shiftClk = 1'b1;
      dataIn = 1'b0;
   end
   // Sends n bits of f, MSB first, at 160 ns per bit; n below 32 aborts.
   task automatic send(input logic [31:0] f, input int n);
      int i;
      @(posedge clk);
      frameSelN <= 1'b0;
      for (i = 31; i > 31 - n; i--) begin
         dataIn <= f[i];
         shiftClk <= 1'b1;
         repeat (4) @(posedge clk);
         shiftClk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      // The data line toggles once released so a stale bit is never reused.
      repeat (4) @(posedge clk);
      frameSelN <= 1'b1;
      shiftClk <= 1'b1;
      dataIn <= ~dataIn;
      repeat (8) @(posedge clk);
   endtask : send
endmodule : qdcc_host
`default_nettype wire

// >>> verif/qdcc_top_tb.sv
// Self-checking bench for the quad converter command control.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
   $display("wrong value %s exp %h got %h", n, e, s); errors++; end end
module qdcc_top_tb
   import qdcc_pkg::*;
;
   logic clk, sys_rst, frameSelN, shiftClk, dataIn, clearN, loadN;
   logic chainEn, vrefEn, clearMode;
   logic [1:0] clearSel;
   logic [3:0] ldMask;
   logic [7:0] pwrMode;
   logic [63:0] dacCode;
   int errors = 0;
   int checks_done = 0;
   qdcc_host i_host (.clk(clk), .frameSelN(frameSelN), .shiftClk(shiftClk),
      .dataIn(dataIn));
   qdcc_top i_dut (.clk(clk), .sys_rst(sys_rst), .frame_sel_n(frameSelN),
      .shift_clk(shiftClk), .data_in(dataIn), .async_clear_n(clearN),
      .load_outputs_n(loadN), .chain_mode_enable(chainEn),
      .vref_enable(vrefEn), .clear_sel(clearSel),
      .load_override_mask(ldMask), .clear_mode(clearMode),
      .pwr_mode(pwrMode), .dac_code(dacCode));
   // Clock of 50 MHz.
   always #10 clk = ~clk;
   function automatic logic [31:0] fr(input logic [3:0] c,
      input logic [3:0] a, input logic [19:0] d);
      return {4'h0, c, a, d};
   endfunction : fr
   task automatic end_of_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic t_reset();
      sys_rst <= 1'b1;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("mask", LDMASK_RST, ldMask);
      `CHK("clrsel", CLRSEL_RST, clearSel);
      `CHK("dac", 64'h0, dacCode);
   endtask : t_reset
   task automatic t_setup();
      for (int v = 0; v < 4; v++) begin
         i_host.send(fr(CMD_SETUP, 4'h5, {18'h2aaaa, 2'(v)}), 32);
         `CHK("setup", 2'(v), {chainEn, vrefEn});
      end
      i_host.send(fr(CMD_SETUP, 4'h0, 20'h0), 31);
      `CHK("short", 2'h3, {chainEn, vrefEn});
   endtask : t_setup
   task automatic t_power();
      for (int m = 0; m < 4; m++) begin
         i_host.send(fr(CMD_PWR, 4'h3, {10'h0, 2'(m), 4'h0, 4'(1 << m)}),
            32);
      end
      `CHK("pwr", {QDCC_PWR_TRI, QDCC_PWR_100K, QDCC_PWR_1K,
         QDCC_PWR_NORMAL}, pwrMode);
      i_host.send(fr(CMD_PWR, 4'h0, {10'h3ff, QDCC_PWR_TRI, 8'hfa}), 32);
      `CHK("pwrsel", 8'hec, pwrMode);
   endtask : t_power
   task automatic t_load();
      i_host.send(fr(CMD_WR_INPUT, 4'h1, {16'h1234, 4'h0}), 32);
      `CHK("hold", 64'h0, dacCode);
      loadN <= 1'b0; // A pulse on the load pin.
      repeat (10) @(posedge clk);
      loadN <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK("pulse", 64'h0000_0000_1234_0000, dacCode);
      loadN <= 1'b0; // Load pin held low.
      i_host.send(fr(CMD_WR_INPUT, 4'h2, {16'h5678, 4'h0}), 32);
      `CHK("sync", 64'h0000_5678_1234_0000, dacCode);
      loadN <= 1'b1;
   endtask : t_load
   task automatic t_override();
      i_host.send(fr(CMD_LDMASK, 4'h7, {16'hffff, 4'h1}), 32);
      `CHK("mask", 4'h1, ldMask);
      i_host.send(fr(CMD_WR_INPUT, 4'h0, {16'haaaa, 4'h0}), 32);
      i_host.send(fr(CMD_WR_INPUT, 4'h3, {16'hbbbb, 4'h0}), 32);
      `CHK("ovr", 64'h0000_5678_1234_aaaa, dacCode);
      i_host.send(fr(CMD_WR_UPD_ONE, 4'h2, {16'hcccc, 4'h0}), 32);
      `CHK("soft", 64'hbbbb_cccc_1234_aaaa, dacCode);
      i_host.send(fr(CMD_WR_INPUT, ADDR_ALL, {16'h0f0f, 4'h0}), 32);
      i_host.send(fr(CMD_UPD_DAC, 4'h0, {16'h0, 4'h4}), 32);
      `CHK("upd", 64'hbbbb_0f0f_1234_0f0f, dacCode);
      i_host.send(fr(CMD_WR_UPD_ALL, 4'h1, {16'h2222, 4'h0}), 32);
      `CHK("updall", 64'h0f0f_0f0f_2222_0f0f, dacCode);
   endtask : t_override
   task automatic t_clear();
      for (int s = 0; s < 4; s++) begin
         i_host.send(fr(CMD_CLRSEL, 4'h0, {18'h0, 2'(s)}), 32);
         `CHK("clrsel", (s == 3) ? 2'h2 : 2'(s), clearSel);
      end
      clearN <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("cmode", 1'b1, clearMode);
      `CHK("clrdac", {4{CLR_FULL}}, dacCode);
      clearN <= 1'b1;
      repeat (10) @(posedge clk);
      // A clear edge in mid-frame; the pin then stays low.
      fork
         i_host.send(fr(CMD_SETUP, 4'h0, 20'h0), 32);
         begin
            repeat (100) @(posedge clk);
            clearN <= 1'b0;
         end
      join
      `CHK("abort", 2'h3, {chainEn, vrefEn});
      `CHK("cmode", 1'b1, clearMode);
      i_host.send(fr(CMD_WR_INPUT, 4'h0, {16'h0001, 4'h0}), 32);
      repeat (20) @(posedge clk);
      `CHK("cmode", 1'b0, clearMode);
      `CHK("exit", {{3{CLR_FULL}}, 16'h0001}, dacCode);
      clearN <= 1'b1;
   endtask : t_clear
   // Watchdog so a hang still reaches the verdict.
   initial begin
      repeat (50000) @(posedge clk);
      errors++;
      end_of_test();
   end
   // Main sequence, ending with a second reset in mid-run.
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      clearN = 1'b1;
      loadN = 1'b1;
      t_reset();
      t_setup();
      t_power();
      t_load();
      t_override();
      t_clear();
      t_reset();
      end_of_test();
   end
endmodule : qdcc_top_tb
`default_nettype wire
